// ### hdl/ccs_common_status.sv
// common command execution and status reporting
// assumes parser, measurement core and self test run on ref_clk
`default_nettype none
module ccs_common_status (
    // clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 resetn,
    // decoded commands
    input  wire logic                 cmdValid,
    input  wire ccs_pkg::ccs_cmd_type cmdCode,
    input  wire logic [7:0]           cmdArg,
    output logic                      cmdReady,
    // responses
    output ccs_pkg::ccs_resp_type     resp,
    // measurement core
    output logic                      measStart,
    input  wire logic                 measDone,
    input  wire logic [31:0]          measResult,
    input  wire logic                 measActive,
    // self test
    output logic                      tstStart,
    input  wire logic                 tstDone,
    input  wire logic [15:0]          tstErrSum,
    // status sources
    input  wire ccs_pkg::ccs_event_type events,
    input  wire logic                 msgAvail,
    input  wire logic                 operSummary,
    // status view
    output logic [7:0]                eventFlags,
    output logic [7:0]                statusByte,
    output logic                      srq
);
    logic [7:0]              esr_q;
    logic [7:0]              ese_q;
    logic [7:0]              sre_q;
    logic [7:0]              stb_q;
    logic                    srq_q;
    logic                    measBusy_q;
    logic                    measHold_q;
    logic [31:0]             measVal_q;
    logic                    measStart_q;
    logic                    tstBusy_q;
    logic                    tstBusy_d;
    logic                    tstStart_q;
    logic                    opcArmed_q;
    logic                    opcQPend_q;
    logic                    opcQPend_d;
    logic                    ready_q;
    ccs_pkg::ccs_resp_type   resp_q;
    logic                    take;
    logic                    isRst;
    logic                    busy;
    logic                    opcSet;
    logic                    immQuery;
    logic                    tstReply;
    logic                    opcReply;
    logic                    measEmit;
    logic [7:0]              evIn;
    logic [7:0]              stbD;

    function automatic logic is_cmd(input logic t, input ccs_pkg::ccs_cmd_type c,
                                    input ccs_pkg::ccs_cmd_type want);
        return t && (c == want);
    endfunction : is_cmd

    assign take     = cmdValid && ready_q;
    assign isRst    = is_cmd(take, cmdCode, ccs_pkg::CMD_RST);
    // measActive covers work the core runs outside a trigger
    assign busy     = measBusy_q || measHold_q || measActive;
    assign opcSet   = opcArmed_q && !busy;
    assign immQuery = take && (cmdCode inside {ccs_pkg::CMD_IDNQ, ccs_pkg::CMD_ESEQ, ccs_pkg::CMD_SREQ,
                                               ccs_pkg::CMD_ESRQ, ccs_pkg::CMD_STBQ});
    assign tstReply = tstBusy_q && tstDone && !isRst;
    assign opcReply = opcQPend_q && !busy && !isRst;
    assign measEmit = measHold_q && !immQuery && !tstReply && !isRst;

    always_comb begin
        evIn = 8'h00;
        evIn[ccs_pkg::EV_URQ] = events.userReq;
        evIn[ccs_pkg::EV_CME] = events.cmdErr;
        evIn[ccs_pkg::EV_EXE] = events.execErr;
        evIn[ccs_pkg::EV_DDE] = events.devErr;
        evIn[ccs_pkg::EV_QYE] = events.queryErr;
        evIn[ccs_pkg::EV_RQC] = events.reqCtrl;
        evIn[ccs_pkg::EV_OPC] = opcSet;
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            esr_q <= ccs_pkg::EVENT_RESET;
        end else if (is_cmd(take, cmdCode, ccs_pkg::CMD_CLS)) begin
            esr_q <= evIn;
        end else begin
            esr_q <= esr_q | evIn;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ese_q <= ccs_pkg::ENABLE_RESET;
            sre_q <= ccs_pkg::ENABLE_RESET;
        end else begin
            if (is_cmd(take, cmdCode, ccs_pkg::CMD_ESE)) begin
                ese_q <= cmdArg;
            end
            if (is_cmd(take, cmdCode, ccs_pkg::CMD_SRE)) begin
                sre_q <= cmdArg;
            end
        end
    end

    // status byte, one cycle behind its sources
    always_comb begin
        stbD = 8'h00;
        stbD[ccs_pkg::SB_OSS] = operSummary;
        stbD[ccs_pkg::SB_ESB] = |(esr_q & ese_q);
        stbD[ccs_pkg::SB_MAV] = msgAvail;
        stbD[ccs_pkg::SB_RQS] = |(stbD & sre_q & ~(8'h01 << ccs_pkg::SB_RQS));
    end

    // queries never write the status byte
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            stb_q <= 8'h00;
            srq_q <= 1'b0;
        end else begin
            stb_q <= stbD;
            srq_q <= stbD[ccs_pkg::SB_RQS];
        end
    end

    // trigger path, a second trigger while busy is ignored
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            measBusy_q  <= 1'b0;
            measHold_q  <= 1'b0;
            measVal_q   <= 32'h0000_0000;
            measStart_q <= 1'b0;
        end else begin
            measStart_q <= is_cmd(take, cmdCode, ccs_pkg::CMD_TRG) && !measBusy_q && !measHold_q;
            if (isRst) begin
                measBusy_q <= 1'b0;
                measHold_q <= 1'b0;
            end else begin
                if (is_cmd(take, cmdCode, ccs_pkg::CMD_TRG) && !measBusy_q && !measHold_q) begin
                    measBusy_q <= 1'b1;
                end else if (measBusy_q && measDone) begin
                    measBusy_q <= 1'b0;
                    measHold_q <= 1'b1;
                    measVal_q  <= measResult;
                end else if (measEmit) begin
                    measHold_q <= 1'b0;
                end
            end
        end
    end

    // long queries hold off further commands
    always_comb begin
        tstBusy_d  = tstBusy_q;
        opcQPend_d = opcQPend_q;
        if (isRst) begin
            tstBusy_d  = 1'b0;
            opcQPend_d = 1'b0;
        end else begin
            if (is_cmd(take, cmdCode, ccs_pkg::CMD_TSTQ)) begin
                tstBusy_d = 1'b1;
            end else if (tstReply) begin
                tstBusy_d = 1'b0;
            end
            if (is_cmd(take, cmdCode, ccs_pkg::CMD_OPCQ)) begin
                opcQPend_d = 1'b1;
            end else if (opcReply) begin
                opcQPend_d = 1'b0;
            end
        end
    end

    // completion command arms the complete flag
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            tstBusy_q  <= 1'b0;
            opcQPend_q <= 1'b0;
            ready_q    <= 1'b0;
            tstStart_q <= 1'b0;
            opcArmed_q <= 1'b0;
        end else begin
            tstBusy_q  <= tstBusy_d;
            opcQPend_q <= opcQPend_d;
            ready_q    <= !tstBusy_d && !opcQPend_d;
            tstStart_q <= is_cmd(take, cmdCode, ccs_pkg::CMD_TSTQ) && !isRst;
            if (isRst || opcSet) begin
                opcArmed_q <= 1'b0;
            end else if (is_cmd(take, cmdCode, ccs_pkg::CMD_OPC)) begin
                opcArmed_q <= 1'b1;
            end
        end
    end

    // response port, immediate queries take precedence
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            resp_q <= '0;
        end else begin
            resp_q <= '0;
            if (immQuery) begin
                resp_q.valid <= 1'b1;
                case (cmdCode)
                    ccs_pkg::CMD_ESEQ: resp_q.value <= {24'h00_0000, ese_q};
                    ccs_pkg::CMD_SREQ: resp_q.value <= {24'h00_0000, sre_q};
                    ccs_pkg::CMD_ESRQ: resp_q.value <= {24'h00_0000, esr_q};
                    ccs_pkg::CMD_STBQ: resp_q.value <= {24'h00_0000, stb_q};
                    ccs_pkg::CMD_IDNQ: resp_q.kind  <= ccs_pkg::RESP_IDENT;
                    default:           resp_q.value <= 32'h0000_0000;
                endcase
            end else if (tstReply) begin
                resp_q.valid <= 1'b1;
                resp_q.value <= {16'h0000, tstErrSum};
            end else if (opcReply) begin
                resp_q.valid <= 1'b1;
                resp_q.value <= ccs_pkg::OPC_ASCII;
            end else if (measEmit) begin
                resp_q.valid <= 1'b1;
                resp_q.kind  <= ccs_pkg::RESP_MEAS;
                resp_q.value <= measVal_q;
            end
        end
    end

    assign cmdReady   = ready_q;
    assign resp       = resp_q;
    assign measStart  = measStart_q;
    assign tstStart   = tstStart_q;
    assign eventFlags = esr_q;
    assign statusByte = stb_q;
    assign srq        = srq_q;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    a_rst_aborts: assert property (isRst |=> !measBusy_q && !tstBusy_q && !opcQPend_q)
        else $error("reset command left work pending");
    a_trg_start: assert property ((is_cmd(take, cmdCode, ccs_pkg::CMD_TRG) && !measBusy_q && !measHold_q)
        |=> measStart && measBusy_q)
        else $error("trigger did not start a measurement");
    a_cls_clear: assert property ((is_cmd(take, cmdCode, ccs_pkg::CMD_CLS) && evIn == 8'h00)
        |=> eventFlags == 8'h00 ##1 statusByte[ccs_pkg::SB_ESB] == 1'b0)
        else $error("clear status left flags set");
    a_tst_reply: assert property (tstReply |=> resp.valid && resp.value == {16'h0000, $past(tstErrSum)})
        else $error("self test reply wrong");
    a_ese_load: assert property (is_cmd(take, cmdCode, ccs_pkg::CMD_ESE) |=> ese_q == $past(cmdArg))
        else $error("event enable not loaded");
    a_sre_load: assert property (is_cmd(take, cmdCode, ccs_pkg::CMD_SRE) |=> sre_q == $past(cmdArg))
        else $error("service enable not loaded");
    a_sre_query: assert property (is_cmd(take, cmdCode, ccs_pkg::CMD_SREQ)
        |=> resp.valid && resp.value[7:0] == $past(sre_q))
        else $error("mask query wrong");
    a_stb_low_zero: assert property ((statusByte & ccs_pkg::SB_ZERO_MASK) == 8'h00)
        else $error("status byte low bits set");
    a_esr_query: assert property (is_cmd(take, cmdCode, ccs_pkg::CMD_ESRQ)
        |=> resp.valid && resp.value[7:0] == $past(esr_q))
        else $error("event query wrong");
    a_stb_query: assert property (is_cmd(take, cmdCode, ccs_pkg::CMD_STBQ)
        |=> resp.value[7:0] == $past(statusByte) && statusByte == $past(stbD))
        else $error("status byte query disturbed state");
    a_opc_flag: assert property ((opcArmed_q && busy) ##1 (opcArmed_q && !busy) |=> esr_q[ccs_pkg::EV_OPC])
        else $error("complete flag not set");
    a_opc_query: assert property (opcReply |=> resp.valid && resp.value == ccs_pkg::OPC_ASCII
        && !$past(busy))
        else $error("completion query reply wrong");
    a_esb_summary: assert property (##1 statusByte[ccs_pkg::SB_ESB] == $past(|(esr_q & ese_q)))
        else $error("event summary wrong");
    a_rqs_srq: assert property (##1 srq == statusByte[ccs_pkg::SB_RQS]
        && srq == $past(|(stbD & sre_q & 8'hBF)))
        else $error("service request wrong");

    c_trg_result: cover property (measStart ##[1:50] (resp.valid && resp.kind == ccs_pkg::RESP_MEAS));
    c_opc_wait: cover property (opcQPend_q && busy ##[1:50] opcReply);
    c_srq_raise: cover property (!srq ##1 srq);
endmodule : ccs_common_status
`default_nettype wire

// ### common/ccs_pkg.sv
// constants and carriers for the common command and status block
// assumes a command parser on the same clock hands over decoded commands
`default_nettype none
package ccs_pkg;
    typedef enum logic [3:0] {
        CMD_RST  = 4'h0,
        CMD_TRG  = 4'h1,
        CMD_IDNQ = 4'h2,
        CMD_TSTQ = 4'h3,
        CMD_ESE  = 4'h4,
        CMD_ESEQ = 4'h5,
        CMD_SRE  = 4'h6,
        CMD_SREQ = 4'h7,
        CMD_ESRQ = 4'h8,
        CMD_STBQ = 4'h9,
        CMD_OPC  = 4'hA,
        CMD_OPCQ = 4'hB,
        CMD_CLS  = 4'hC
    } ccs_cmd_type;

    typedef enum logic [1:0] {
        RESP_VALUE = 2'h0,
        RESP_MEAS  = 2'h1,
        RESP_IDENT = 2'h2
    } ccs_kind_type;

    localparam int RESP_W = 32;

    typedef struct packed {
        logic                valid;
        ccs_kind_type        kind;
        logic [RESP_W-1:0]   value;
    } ccs_resp_type;

    typedef struct packed {
        logic userReq;
        logic cmdErr;
        logic execErr;
        logic devErr;
        logic queryErr;
        logic reqCtrl;
    } ccs_event_type;

    // event flag positions
    localparam int EV_PON = 7;
    localparam int EV_URQ = 6;
    localparam int EV_CME = 5;
    localparam int EV_EXE = 4;
    localparam int EV_DDE = 3;
    localparam int EV_QYE = 2;
    localparam int EV_RQC = 1;
    localparam int EV_OPC = 0;
    // status byte positions
    localparam int SB_OSS = 7;
    localparam int SB_RQS = 6;
    localparam int SB_ESB = 5;
    localparam int SB_MAV = 4;

    localparam logic [7:0]        EVENT_RESET  = 8'h80;
    localparam logic [7:0]        ENABLE_RESET = 8'h00;
    localparam logic [7:0]        SB_ZERO_MASK = 8'h0F;
    localparam logic [RESP_W-1:0] OPC_ASCII    = 32'h0000_0031;
endpackage : ccs_pkg
`default_nettype wire

// ### testbench/ccs_meas_model.sv
// behavioural measurement core and self test engine
// assumes start pulses on ref_clk; answers after a latency set by the bench
`default_nettype none
module ccs_meas_model (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    // measurement core
    input  wire logic        measStart,
    output logic             measDone,
    output logic [31:0]      measResult,
    output logic             measActive,
    // self test
    input  wire logic        tstStart,
    output logic             tstDone,
    output logic [15:0]      tstErrSum,
    // settings from the bench
    input  wire logic [31:0] resultVal,
    input  wire logic [15:0] errSumVal,
    input  wire logic [7:0]  latency
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mCnt;
    logic [7:0] tCnt;
    // data lines toggle outside their valid cycle so a value taken one cycle late never matches
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            mCnt       <= 8'h00;
            measActive <= 1'b0;
            measDone   <= 1'b0;
            measResult <= 32'h0000_0000;
        end else begin
            measDone   <= (mCnt == 8'h01);
            measResult <= (mCnt == 8'h01) ? resultVal : ~measResult;
            measActive <= measStart || (mCnt > 8'h01);
            mCnt       <= measStart ? latency : ((mCnt != 8'h00) ? mCnt - 8'h01 : 8'h00);
        end
    end
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            tCnt      <= 8'h00;
            tstDone   <= 1'b0;
            tstErrSum <= 16'h0000;
        end else begin
            tstDone   <= (tCnt == 8'h01);
            tstErrSum <= (tCnt == 8'h01) ? errSumVal : ~tstErrSum;
            tCnt      <= tstStart ? latency : ((tCnt != 8'h00) ? tCnt - 8'h01 : 8'h00);
        end
    end
endmodule : ccs_meas_model
`default_nettype wire

// ### testbench/tb_common_command_status_reporting.sv
// self-checking bench for common command and status logic
// assumes ccs_meas_model stands in for the measurement core and self test
`default_nettype none
module tb_common_command_status_reporting;
    timeunit 1ns;
    timeprecision 1ps;
    logic                  ref_clk, resetn, cmdValid, cmdReady, measStart, measDone, measActive;
    logic                  tstStart, tstDone, msgAvail, operSummary, srq;
    ccs_pkg::ccs_cmd_type  cmdCode;
    ccs_pkg::ccs_resp_type resp, respExp, expQ[$];
    ccs_pkg::ccs_event_type events;
    logic [7:0]            cmdArg, eventFlags, statusByte, evExp, eseV, sreV, latency;
    logic [31:0]           measResult, resultVal, rnd;
    logic [15:0]           tstErrSum, errSumVal;
    int                    errors, checks, seed;
    always #5 ref_clk = ~ref_clk;
    ccs_common_status u_dut (.ref_clk(ref_clk), .resetn(resetn), .cmdValid(cmdValid), .cmdCode(cmdCode),
        .cmdArg(cmdArg), .cmdReady(cmdReady), .resp(resp), .measStart(measStart), .measDone(measDone),
        .measResult(measResult), .measActive(measActive), .tstStart(tstStart), .tstDone(tstDone),
        .tstErrSum(tstErrSum), .events(events), .msgAvail(msgAvail), .operSummary(operSummary),
        .eventFlags(eventFlags), .statusByte(statusByte), .srq(srq));
    ccs_meas_model u_meas (.ref_clk(ref_clk), .resetn(resetn), .measStart(measStart), .measDone(measDone),
        .measResult(measResult), .measActive(measActive), .tstStart(tstStart), .tstDone(tstDone),
        .tstErrSum(tstErrSum), .resultVal(resultVal), .errSumVal(errSumVal), .latency(latency));
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : tally_and_finish
    task automatic check8(string nm, logic [7:0] exp, logic [7:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : check8
    function automatic void noteResp(ccs_pkg::ccs_kind_type k, logic [31:0] v);
        expQ.push_back({1'b1, k, v});
    endfunction : noteResp
    function automatic logic [7:0] stbExp();
        logic [7:0] s;
        s = {operSummary, 1'b0, |(evExp & eseV), msgAvail, 4'h0};
        s[6] = |(s & sreV & 8'hB0);
        return s;
    endfunction : stbExp
    // held until taken; one idle edge between commands
    task automatic sendCmd(ccs_pkg::ccs_cmd_type c, logic [7:0] a);
        int n;
        n = 0;
        @(posedge ref_clk);
        cmdValid <= 1'b1;
        cmdCode  <= c;
        cmdArg   <= a;
        do begin
            @(posedge ref_clk);
            n++;
        end while (cmdReady !== 1'b1 && n < 300);
        cmdValid <= 1'b0;
        if (n >= 300) begin
            errors++;
            $display("Error cmdReady expected 1 seen %b", cmdReady);
        end
    endtask : sendCmd
    task automatic drain();
        int n;
        n = 0;
        while (expQ.size() != 0 && n < 500) begin
            @(posedge ref_clk);
            n++;
        end
        repeat (4) @(posedge ref_clk);
        check8("pending answers", 8'h00, 8'(expQ.size()));
    endtask : drain
    task automatic checkStatus();
        logic [7:0] s;
        repeat (3) @(posedge ref_clk);
        s = stbExp();
        check8("eventFlags", evExp, eventFlags);
        check8("statusByte", s, statusByte);
        check8("srq", {7'h00, s[6]}, {7'h00, srq});
    endtask : checkStatus
    task automatic pulseEv(int b);
        @(posedge ref_clk);
        events <= ccs_pkg::ccs_event_type'(6'h01 << (b - 1));
        @(posedge ref_clk);
        events <= '0;
        evExp[b] = 1'b1;
    endtask : pulseEv
    // answers leave in order, so the oldest note belongs to each answer
    always @(posedge ref_clk) begin
        if (resp.valid === 1'b1) begin
            checks++;
            if (expQ.size() == 0) begin
                errors++;
                $display("Error resp expected none seen %h", resp);
            end else begin
                respExp = expQ.pop_front();
                if (resp !== respExp) begin
                    errors++;
                    $display("Error resp expected %h seen %h", respExp, resp);
                end
            end
        end
    end
    initial begin
        #300000;
        errors++;
        $display("Error watchdog expected end seen hang");
        tally_and_finish();
    end
    initial begin
        seed = 32'h2dfddae4;
        {ref_clk, resetn, cmdValid, cmdArg, msgAvail, operSummary, errSumVal} = '0;
        cmdCode = ccs_pkg::CMD_RST;
        events = '0;
        rnd = $random(seed);
        resultVal = rnd;
        latency = 8'h06 + {5'h00, rnd[2:0]};
        repeat (3) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (2) @(posedge ref_clk);
        {evExp, eseV, sreV} = {8'h80, 8'h00, 8'h00};
        checkStatus();
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            rnd = $random(seed);
            {eseV, sreV} = rnd[15:0];
            sendCmd(ccs_pkg::CMD_ESE, eseV);
            sendCmd(ccs_pkg::CMD_SRE, sreV);
            noteResp(ccs_pkg::RESP_VALUE, {24'h0000_00, eseV});
            sendCmd(ccs_pkg::CMD_ESEQ, 8'h00);
            noteResp(ccs_pkg::RESP_VALUE, {24'h0000_00, sreV});
            sendCmd(ccs_pkg::CMD_SREQ, 8'h00);
            drain();
        end
        noteResp(ccs_pkg::RESP_VALUE, {24'h0000_00, evExp});
        sendCmd(ccs_pkg::CMD_ESRQ, 8'h00);
        // identity answer carries only its kind; the text is added downstream
        noteResp(ccs_pkg::RESP_IDENT, 32'h0000_0000);
        sendCmd(ccs_pkg::CMD_IDNQ, 8'h00);
        drain();
        $display("test masks done");
        {eseV, sreV} = {8'hFF, 8'h20};
        sendCmd(ccs_pkg::CMD_ESE, eseV);
        sendCmd(ccs_pkg::CMD_SRE, sreV);
        evExp = 8'h00;
        sendCmd(ccs_pkg::CMD_CLS, 8'h00);
        checkStatus();
        for (int b = 1; b < 7; b++) begin
            pulseEv(b);
            checkStatus();
        end
        msgAvail <= 1'b1;
        operSummary <= 1'b1;
        sreV = 8'h10;
        sendCmd(ccs_pkg::CMD_SRE, sreV);
        checkStatus();
        for (int i = 0; i < 2; i++) begin
            noteResp(ccs_pkg::RESP_VALUE, {24'h0000_00, stbExp()});
            sendCmd(ccs_pkg::CMD_STBQ, 8'h00);
        end
        drain();
        checkStatus();
        evExp = 8'h00;
        sendCmd(ccs_pkg::CMD_CLS, 8'h00);
        checkStatus();
        $display("test status done");
        rnd = $random(seed);
        resultVal <= rnd;
        noteResp(ccs_pkg::RESP_MEAS, rnd);
        sendCmd(ccs_pkg::CMD_TRG, 8'h00);
        sendCmd(ccs_pkg::CMD_TRG, 8'h00);
        drain();
        noteResp(ccs_pkg::RESP_MEAS, rnd);
        sendCmd(ccs_pkg::CMD_TRG, 8'h00);
        sendCmd(ccs_pkg::CMD_OPC, 8'h00);
        // look after the arm has settled; the measurement is still running
        repeat (2) @(posedge ref_clk);
        check8("early complete flag", 8'h00, {7'h00, eventFlags[0]});
        drain();
        evExp[0] = 1'b1;
        checkStatus();
        noteResp(ccs_pkg::RESP_MEAS, rnd);
        sendCmd(ccs_pkg::CMD_TRG, 8'h00);
        noteResp(ccs_pkg::RESP_VALUE, ccs_pkg::OPC_ASCII);
        sendCmd(ccs_pkg::CMD_OPCQ, 8'h00);
        drain();
        $display("test trigger done");
        for (int i = 0; i < 2; i++) begin
            rnd = (i == 0) ? 32'h0000_0000 : $random(seed);
            errSumVal <= rnd[15:0];
            noteResp(ccs_pkg::RESP_VALUE, {16'h0000, rnd[15:0]});
            sendCmd(ccs_pkg::CMD_TSTQ, 8'h00);
            drain();
        end
        $display("test self test done");
        sendCmd(ccs_pkg::CMD_TRG, 8'h00);
        sendCmd(ccs_pkg::CMD_RST, 8'h00);
        repeat (30) @(posedge ref_clk);
        drain();
        noteResp(ccs_pkg::RESP_VALUE, ccs_pkg::OPC_ASCII);
        sendCmd(ccs_pkg::CMD_OPCQ, 8'h00);
        drain();
        $display("test reset command done");
        tally_and_finish();
    end
endmodule : tb_common_command_status_reporting
`default_nettype wire
